// [rtl/edge_pick.sv]
`timescale 1ns/1ps
// edge detector for one external interrupt pin, edge chosen by a select
// assumes the pin is already synchronous to core_clk
module edge_pick
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // pin and select
    input  wire logic pin,
    input  wire logic rising,
    // detected edge
    output logic      hit
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic prev;
        logic primed;
        logic hit;
    } edge_st_s;

    edge_st_s st_r;
    edge_st_s st_nxt;

    // next state: compare with last sample
    always_comb
    begin
        st_nxt      = st_r;
        st_nxt.prev   = pin;
        st_nxt.primed = 1'b1;
        st_nxt.hit    = st_r.primed & (rising ? (pin & ~st_r.prev) : (~pin & st_r.prev));
    end

    // register; no edge until one real sample is held, so a pin high at release is quiet
    always_ff @(posedge core_clk)
    begin
        if (rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign hit = st_r.hit;

endmodule

// [rtl/irq_flags.sv]
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// interrupt flag block: external pins one and two, first peripheral flag bank
// assumes apb master on core_clk, event inputs synchronous, one-cycle pulses except the rx_full and tx_empty levels
// Functional notes
// - flags set on event regardless of enables
// - conversion done sets bit 6, software clears
// - bit 5 read-only, follows receive buffer
// - bit 4 read-only, follows transmit buffer
// - capture mode: capture sets bit 2
// - compare mode: match sets bit 2; pwm unused
// - period match sets bit 1, software clears
// - timer overflow sets bit 0, software clears
// - bits 7 and 3 read zero
// - no priority: peripheral needs group enable
module irq_flags
(
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // event sources
    input  wire irq_flags_pkg::periph_ev_s  periph_ev,
    input  wire logic                       ext_pin_one,
    input  wire logic                       ext_pin_two,
    input  wire logic                       pin_one_rising,
    input  wire logic                       pin_two_rising,
    // peripheral enables (held in a neighbouring register)
    input  wire logic [7:0]                 periph_enables,
    input  wire logic [7:0]                 periph_priority,
    // requests to core
    output irq_flags_pkg::irq_req_s         irq_req
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [7:0]               ext_ctrl;
        logic [7:0]               pflags;
        logic [7:0]               gctrl;
        logic [31:0]              rdata;
        irq_flags_pkg::irq_req_s  req;
    } irq_st_s;

    irq_st_s st_r;
    irq_st_s st_nxt;

    logic pin_one_hit;
    logic pin_two_hit;
    logic wr_acc;
    logic rd_setup;
    logic hit_map;
    logic cc_event;
    irq_flags_pkg::capcmp_mode_e cc_mode;
    logic [7:0] pflag_view;
    logic [7:0] active;
    logic       ext_one_act;
    logic       ext_two_act;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == irq_flags_pkg::ext_ctrl_off) || (a == irq_flags_pkg::periph_flag_off)
              || (a == irq_flags_pkg::global_ctrl_off) || (a == irq_flags_pkg::req_stat_off);
    endfunction

    // software write of a flag word: writable bits take data, set event wins
    function automatic logic [7:0] sw_merge(input logic [7:0] cur, input logic [7:0] wd,
                                            input logic [7:0] wmask, input logic [7:0] sets);
        sw_merge = ((cur & ~wmask) | (wd & wmask)) | sets;
    endfunction

    // zero-wait slave: the access phase completes in its first cycle
    assign hit_map = mapped(paddr);
    assign wr_acc  = psel & penable & pwrite;
    // read word is loaded in the setup cycle so it stands through the access phase
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_map;
    assign prdata  = st_r.rdata;

    // ****************************************
    // event detection
    // ****************************************
    edge_pick u_pin_one
    (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (ext_pin_one),
        .rising   (pin_one_rising),
        .hit      (pin_one_hit)
    );

    edge_pick u_pin_two
    (
        .core_clk (core_clk),
        .rst      (rst),
        .pin      (ext_pin_two),
        .rising   (pin_two_rising),
        .hit      (pin_two_hit)
    );

    // capcmp source depends on the unit's mode; pwm leaves the flag alone
    assign cc_mode  = irq_flags_pkg::capcmp_mode_e'(
                      st_r.gctrl[irq_flags_pkg::capcmp_mode_lsb +: 2]);
    always_comb
    begin
        case (cc_mode)
            irq_flags_pkg::cc_capture: cc_event = periph_ev.capture;
            irq_flags_pkg::cc_compare: cc_event = periph_ev.compare;
            irq_flags_pkg::cc_pwm:     cc_event = 1'b0;
            default:                   cc_event = 1'b0;
        endcase
    end

    // read-only buffer status bits are live views, not stored
    always_comb
    begin
        pflag_view = st_r.pflags;
        pflag_view[irq_flags_pkg::rx_full_bit]  = periph_ev.rx_full;
        pflag_view[irq_flags_pkg::tx_empty_bit] = periph_ev.tx_empty;
        pflag_view[7] = 1'b0;
        pflag_view[3] = 1'b0;
    end

    // ****************************************
    // request gating
    // ****************************************
    assign active = pflag_view & periph_enables;
    assign ext_one_act = st_r.ext_ctrl[irq_flags_pkg::pin_one_flag_bit]
                       & st_r.ext_ctrl[irq_flags_pkg::pin_one_enable_bit];
    assign ext_two_act = st_r.ext_ctrl[irq_flags_pkg::pin_two_flag_bit]
                       & st_r.ext_ctrl[irq_flags_pkg::pin_two_enable_bit];

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic [7:0] psets;
        logic [7:0] esets;
        logic       global_irq_enable;
        logic       periph_group_enable;
        logic       priority_levels_on;
        logic       ext_hi;
        logic       ext_lo;
        logic       per_hi;
        logic       per_lo;
        psets  = 8'h00;
        esets  = 8'h00;
        {global_irq_enable, periph_group_enable, priority_levels_on, ext_hi, ext_lo, per_hi, per_lo} = 7'h00;
        st_nxt = st_r;

        // hardware sets, independent of every enable
        psets[irq_flags_pkg::conv_done_bit]    = periph_ev.conv_done;
        psets[irq_flags_pkg::capcmp_bit]       = cc_event;
        psets[irq_flags_pkg::period_match_bit] = periph_ev.period_match;
        psets[irq_flags_pkg::overflow_bit]     = periph_ev.overflow;
        esets[irq_flags_pkg::pin_one_flag_bit] = pin_one_hit;
        esets[irq_flags_pkg::pin_two_flag_bit] = pin_two_hit;

        st_nxt.pflags = st_r.pflags | psets;
        st_nxt.ext_ctrl = st_r.ext_ctrl | esets;

        // register writes; set in the same cycle still wins
        if (wr_acc)
        begin
            case (paddr)
                irq_flags_pkg::ext_ctrl_off:
                    st_nxt.ext_ctrl = sw_merge(st_r.ext_ctrl, pwdata[7:0],
                                               irq_flags_pkg::ext_ctrl_wmask, esets);
                irq_flags_pkg::periph_flag_off:
                    st_nxt.pflags = sw_merge(st_r.pflags, pwdata[7:0],
                                             irq_flags_pkg::periph_flag_wmask, psets);
                irq_flags_pkg::global_ctrl_off:
                    st_nxt.gctrl = {2'b00, pwdata[5:4], 1'b0, pwdata[2:0]};
                default:
                    st_nxt.gctrl = st_r.gctrl;
            endcase
        end

        // read data registered at the setup edge, valid while pready is high
        if (rd_setup)
        begin
            case (paddr)
                irq_flags_pkg::ext_ctrl_off:    st_nxt.rdata = {24'h000000, st_r.ext_ctrl};
                irq_flags_pkg::periph_flag_off: st_nxt.rdata = {24'h000000, pflag_view};
                irq_flags_pkg::global_ctrl_off: st_nxt.rdata = {24'h000000, st_r.gctrl};
                irq_flags_pkg::req_stat_off:    st_nxt.rdata = {30'h0, st_r.req};
                default:                        st_nxt.rdata = 32'h00000000;
            endcase
        end

        // request outputs
        global_irq_enable  = st_r.gctrl[irq_flags_pkg::global_irq_enable_bit];
        periph_group_enable = st_r.gctrl[irq_flags_pkg::periph_group_enable_bit];
        priority_levels_on = st_r.gctrl[irq_flags_pkg::priority_levels_on_bit];
        ext_hi = (ext_one_act & st_r.ext_ctrl[irq_flags_pkg::pin_one_priority_bit])
               | (ext_two_act & st_r.ext_ctrl[irq_flags_pkg::pin_two_priority_bit]);
        ext_lo = (ext_one_act & ~st_r.ext_ctrl[irq_flags_pkg::pin_one_priority_bit])
               | (ext_two_act & ~st_r.ext_ctrl[irq_flags_pkg::pin_two_priority_bit]);
        per_hi = |(active & periph_priority);
        per_lo = |(active & ~periph_priority);
        if (priority_levels_on)
        begin
            // two levels: bit 0 enables high and low, bit 1 also needed for low
            st_nxt.req.irq_high = global_irq_enable & (ext_hi | per_hi);
            st_nxt.req.irq_low  = global_irq_enable & periph_group_enable & (ext_lo | per_lo);
        end
        else
        begin
            // single level: peripherals also need the group enable
            st_nxt.req.irq_high = global_irq_enable & ((ext_hi | ext_lo) | (periph_group_enable & (|active)));
            st_nxt.req.irq_low  = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            st_r.ext_ctrl <= irq_flags_pkg::ext_ctrl_rst;
            st_r.pflags   <= irq_flags_pkg::periph_flag_rst;
            st_r.gctrl    <= irq_flags_pkg::global_ctrl_rst;
            st_r.rdata    <= 32'h00000000;
            st_r.req      <= '0;
        end
        else
            st_r <= st_nxt;
    end

    assign irq_req = st_r.req;

    // ****************************************
    // checks
    // ****************************************
    sequence s_conv_pulse;
        periph_ev.conv_done;
    endsequence

    sequence s_flag_held;
        st_r.pflags[irq_flags_pkg::conv_done_bit] [*2];
    endsequence

    a_conv_sets_flag: assert property (@(posedge core_clk) disable iff (rst)
        s_conv_pulse |=> s_flag_held or
        (st_r.pflags[irq_flags_pkg::conv_done_bit] ##1 1'b1))
        else $error("conversion done did not set flag");

    a_overflow_sets: assert property (@(posedge core_clk) disable iff (rst)
        periph_ev.overflow |=> st_r.pflags[irq_flags_pkg::overflow_bit])
        else $error("overflow flag not set");

    a_period_sets: assert property (@(posedge core_clk) disable iff (rst)
        periph_ev.period_match |=> st_r.pflags[irq_flags_pkg::period_match_bit])
        else $error("period match flag not set");

    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.pflags[irq_flags_pkg::overflow_bit] && !(wr_acc &&
         paddr == irq_flags_pkg::periph_flag_off))
        |=> st_r.pflags[irq_flags_pkg::overflow_bit])
        else $error("overflow flag dropped without write");

    a_capture_mode: assert property (@(posedge core_clk) disable iff (rst)
        (cc_mode == irq_flags_pkg::cc_capture && periph_ev.capture)
        |=> st_r.pflags[irq_flags_pkg::capcmp_bit])
        else $error("capture did not set flag");

    a_pwm_ignored: assert property (@(posedge core_clk) disable iff (rst)
        (cc_mode == irq_flags_pkg::cc_pwm && !st_r.pflags[irq_flags_pkg::capcmp_bit]
         && !wr_acc) |=> !st_r.pflags[irq_flags_pkg::capcmp_bit])
        else $error("capcmp flag set in pwm mode");

    a_rx_view: assert property (@(posedge core_clk) disable iff (rst)
        rd_setup && paddr == irq_flags_pkg::periph_flag_off
        |=> prdata[irq_flags_pkg::rx_full_bit] == $past(periph_ev.rx_full)
            && prdata[irq_flags_pkg::tx_empty_bit] == $past(periph_ev.tx_empty))
        else $error("buffer status bits not live");

    a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst)
        !st_r.rdata[7] || !($past(paddr) == irq_flags_pkg::periph_flag_off))
        else $error("unimplemented bit read as one");

    a_pin_edge: assert property (@(posedge core_clk) disable iff (rst)
        pin_one_hit |=> st_r.ext_ctrl[irq_flags_pkg::pin_one_flag_bit])
        else $error("pin one edge did not set flag");

    a_group_gate: assert property (@(posedge core_clk) disable iff (rst)
        (!st_r.gctrl[irq_flags_pkg::priority_levels_on_bit] && !ext_one_act && !ext_two_act
         && !st_r.gctrl[irq_flags_pkg::periph_group_enable_bit]) |=> !irq_req.irq_high)
        else $error("peripheral request passed without group enable");

    a_no_gie: assert property (@(posedge core_clk) disable iff (rst)
        !st_r.gctrl[irq_flags_pkg::global_irq_enable_bit]
        |=> !irq_req.irq_high && !irq_req.irq_low)
        else $error("request raised with global enable off");

    a_conv_held: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.pflags[irq_flags_pkg::conv_done_bit] && !(wr_acc &&
         paddr == irq_flags_pkg::periph_flag_off))
        |=> st_r.pflags[irq_flags_pkg::conv_done_bit])
        else $error("conversion flag dropped without write");

    a_compare_mode: assert property (@(posedge core_clk) disable iff (rst)
        (cc_mode == irq_flags_pkg::cc_compare && periph_ev.compare)
        |=> st_r.pflags[irq_flags_pkg::capcmp_bit])
        else $error("compare match did not set flag");

    a_capcmp_held: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.pflags[irq_flags_pkg::capcmp_bit] && !(wr_acc &&
         paddr == irq_flags_pkg::periph_flag_off))
        |=> st_r.pflags[irq_flags_pkg::capcmp_bit])
        else $error("capcmp flag dropped without write");

    a_pin_two_edge: assert property (@(posedge core_clk) disable iff (rst)
        pin_two_hit |=> st_r.ext_ctrl[irq_flags_pkg::pin_two_flag_bit])
        else $error("pin two edge did not set flag");

    a_ext_held: assert property (@(posedge core_clk) disable iff (rst)
        (st_r.ext_ctrl[irq_flags_pkg::pin_one_flag_bit] && !(wr_acc &&
         paddr == irq_flags_pkg::ext_ctrl_off))
        |=> st_r.ext_ctrl[irq_flags_pkg::pin_one_flag_bit])
        else $error("pin one flag dropped without write");

    a_low_gated: assert property (@(posedge core_clk) disable iff (rst)
        !st_r.gctrl[irq_flags_pkg::periph_group_enable_bit]
        |=> !irq_req.irq_low)
        else $error("low request raised with group enable off");

endmodule

// [shared/irq_flags_pkg.sv]
// package for the peripheral and external-pin interrupt flag block
// assumes an apb slave with 32-bit data and one aligned word per register
package irq_flags_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] ext_ctrl_off    = 8'h00;  // ext_irq_ctrl_three
    localparam logic [7:0] periph_flag_off = 8'h04;  // periph_irq_flags_one
    localparam logic [7:0] global_ctrl_off = 8'h08;  // global enables, capcmp mode
    localparam logic [7:0] req_stat_off    = 8'h0c;  // request outputs (read only)

    // ext_irq_ctrl_three fields
    localparam int pin_two_priority_bit = 7;
    localparam int pin_one_priority_bit = 6;
    localparam int pin_two_enable_bit   = 4;
    localparam int pin_one_enable_bit   = 3;
    localparam int pin_two_flag_bit     = 1;
    localparam int pin_one_flag_bit     = 0;
    localparam logic [7:0] ext_ctrl_rst = 8'hc0;
    localparam logic [7:0] ext_ctrl_wmask = 8'hdb;

    // periph_irq_flags_one fields
    localparam int conv_done_bit    = 6;
    localparam int rx_full_bit      = 5;
    localparam int tx_empty_bit     = 4;
    localparam int capcmp_bit       = 2;
    localparam int period_match_bit = 1;
    localparam int overflow_bit     = 0;
    localparam logic [7:0] periph_flag_rst   = 8'h00;
    localparam logic [7:0] periph_flag_wmask = 8'h47;

    // global control fields
    localparam int global_irq_enable_bit   = 0;
    localparam int periph_group_enable_bit = 1;
    localparam int priority_levels_on_bit  = 2;
    localparam int capcmp_mode_lsb         = 4;
    localparam logic [7:0] global_ctrl_rst = 8'h00;

    // capture/compare unit modes
    typedef enum logic [1:0] {cc_off, cc_capture, cc_compare, cc_pwm} capcmp_mode_e;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic        conv_done;     // conversion complete pulse
        logic        rx_full;       // receive buffer holds data (level)
        logic        tx_empty;      // transmit buffer empty (level)
        logic        capture;       // capture event pulse
        logic        compare;       // compare match pulse
        logic        period_match;  // timer_b_count equals timer_b_period pulse
        logic        overflow;      // timer_a_count overflow pulse
    } periph_ev_s;

    typedef struct packed {
        logic irq_high;   // high priority (or only) request
        logic irq_low;    // low priority request
    } irq_req_s;

endpackage

// [test/ev_source.sv]
`timescale 1ns/1ps
// far-side model: converter, serial port, capture/compare unit and timers
// assumes one-cycle command pulses from the bench, synchronous to core_clk
module ev_source
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // commands from the bench
    input  wire logic [4:0]            fire,
    input  wire logic                  rx_arrive,
    input  wire logic                  rx_take,
    input  wire logic                  tx_load,
    input  wire logic                  tx_sent,
    // events into the flag block
    output irq_flags_pkg::periph_ev_s  periph_ev
);
    logic rx_full_r;
    logic tx_empty_r;

    // serial buffers are levels: a take or load wins over a new arrival
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            rx_full_r  <= 1'b0;
            tx_empty_r <= 1'b1;
        end
        else
        begin
            rx_full_r  <= (rx_full_r | rx_arrive) & ~rx_take;
            tx_empty_r <= (tx_empty_r | tx_sent) & ~tx_load;
        end
    end

    // one-cycle event pulses straight from the commands
    assign periph_ev = '{conv_done: fire[4], rx_full: rx_full_r, tx_empty: tx_empty_r,
                         capture: fire[3], compare: fire[2], period_match: fire[1],
                         overflow: fire[0]};
endmodule

// [test/irq_flags_bench.sv]
`timescale 1ns/1ps
// self-checking bench for the interrupt flag block
// assumes an apb slave whose read data stands in the access phase
module irq_flags_bench;
    logic                      core_clk;
    logic                      rst;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [7:0]                paddr;
    logic [31:0]               pwdata;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    irq_flags_pkg::periph_ev_s periph_ev;
    logic                      ext_pin_one;
    logic                      ext_pin_two;
    logic                      pin_one_rising;
    logic                      pin_two_rising;
    logic [7:0]                periph_enables;
    logic [7:0]                periph_priority;
    irq_flags_pkg::irq_req_s   irq_req;
    logic [8:0]                cmd;
    logic [7:0]                exp_q[$];
    string                     name_q[$];
    int                        n_mismatch;
    int                        checks_done;
    int                        cycles;
    int                        seed;
    logic [7:0]                rnd;
    int                        ev_bit[3] = '{6, 1, 0};
    int                        ev_cmd[3] = '{4, 1, 0};
    logic [7:0]                t_glb[5] = '{8'h01, 8'h03, 8'h07, 8'h07, 8'h07};
    logic [7:0]                t_en[5]  = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
    logic [7:0]                t_pr[5]  = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01};
    logic [1:0]                t_req[5] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h0};

    irq_flags u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_ev(periph_ev), .ext_pin_one(ext_pin_one),
        .ext_pin_two(ext_pin_two), .pin_one_rising(pin_one_rising),
        .pin_two_rising(pin_two_rising), .periph_enables(periph_enables),
        .periph_priority(periph_priority), .irq_req(irq_req));

    ev_source u_src (.core_clk(core_clk), .rst(rst), .fire(cmd[4:0]), .rx_arrive(cmd[5]),
        .rx_take(cmd[6]), .tx_load(cmd[7]), .tx_sent(cmd[8]), .periph_ev(periph_ev));

    // ****************************************
    // clock, timeout, checking
    // ****************************************
    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic give_verdict();
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask

    // generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // read data is taken at the edge that completes the access phase
    always @(posedge core_clk)
    begin
        if (psel === 1'b1 && penable === 1'b1 && pwrite === 1'b0 && pready === 1'b1)
            check(name_q.pop_front(), {24'h0, exp_q.pop_front()}, prdata);
    end

    // ****************************************
    // drivers
    // ****************************************
    task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        check("pslverr", {31'h0, a > 8'h0c}, {31'h0, pslverr});
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        exp_q.push_back(e);
        name_q.push_back(nm);
        apb(1'b0, a, 8'h00);
    endtask

    // one-cycle command to the far-side model, then time for the flag to land
    task automatic pulse(input int b);
        cmd <= 9'h001 << b;
        @(posedge core_clk);
        cmd <= 9'h000;
        repeat (4) @(posedge core_clk);
    endtask

    task automatic req_is(input logic [1:0] e);
        repeat (4) @(posedge core_clk);
        check("irq_req", {30'h0, e}, {30'h0, irq_req});
        rd(irq_flags_pkg::req_stat_off, {6'h0, e}, "req_stat");
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        seed = 96740;
        {psel, penable, pwrite, paddr, pwdata, cmd} = '0;
        {ext_pin_one, ext_pin_two, pin_one_rising, pin_two_rising} = 4'b0110;
        periph_enables = 8'h00;
        periph_priority = 8'h00;
        rst = 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        rd(irq_flags_pkg::ext_ctrl_off, irq_flags_pkg::ext_ctrl_rst, "ext_ctrl");
        rd(irq_flags_pkg::periph_flag_off, 8'h10, "flags");
        rd(irq_flags_pkg::global_ctrl_off, 8'h00, "global_ctrl");
        rd(8'h10, 8'h00, "unmapped");
        wr(irq_flags_pkg::periph_flag_off, 8'h88);
        rd(irq_flags_pkg::periph_flag_off, 8'h10, "unimpl");
        // timer and converter flags with every enable off, cleared by software
        foreach (ev_bit[i])
        begin
            pulse(ev_cmd[i]);
            rd(irq_flags_pkg::periph_flag_off, 8'h10 | (8'h01 << ev_bit[i]), "ev");
            req_is(2'h0);
            wr(irq_flags_pkg::periph_flag_off, 8'h00);
            rd(irq_flags_pkg::periph_flag_off, 8'h10, "ev_clr");
        end
        // capture/compare flag follows the selected mode only
        for (int m = 0; m < 4; m++)
        begin
            wr(irq_flags_pkg::global_ctrl_off, 8'(m << irq_flags_pkg::capcmp_mode_lsb));
            pulse(3);
            pulse(2);
            rd(irq_flags_pkg::periph_flag_off, (m == 1 || m == 2) ? 8'h14 : 8'h10, "cc");
            wr(irq_flags_pkg::periph_flag_off, 8'h00);
        end
        // serial bits are live and ignore writes
        pulse(5);
        wr(irq_flags_pkg::periph_flag_off, 8'h00);
        rd(irq_flags_pkg::periph_flag_off, 8'h30, "rx_full");
        pulse(6);
        pulse(7);
        rd(irq_flags_pkg::periph_flag_off, 8'h00, "rx_tx_clr");
        pulse(8);
        // random priorities and enables on the pin register
        rnd = 8'($random(seed));
        wr(irq_flags_pkg::ext_ctrl_off, rnd & 8'hd8);
        rd(irq_flags_pkg::ext_ctrl_off, rnd & 8'hd8, "ext_rand");
        wr(irq_flags_pkg::ext_ctrl_off, 8'hc0);
        ext_pin_one <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(irq_flags_pkg::ext_ctrl_off, 8'hc1, "pin_one");
        ext_pin_two <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(irq_flags_pkg::ext_ctrl_off, 8'hc3, "pin_two");
        wr(irq_flags_pkg::ext_ctrl_off, 8'hc9);
        rd(irq_flags_pkg::ext_ctrl_off, 8'hc9, "pin_clr");
        req_is(2'h0);
        wr(irq_flags_pkg::global_ctrl_off, 8'h01);
        req_is(2'h2);
        wr(irq_flags_pkg::ext_ctrl_off, 8'hc8);
        req_is(2'h0);
        // peripheral requests through group and priority settings
        pulse(0);
        foreach (t_glb[i])
        begin
            periph_enables <= t_en[i];
            periph_priority <= t_pr[i];
            wr(irq_flags_pkg::global_ctrl_off, t_glb[i]);
            req_is(t_req[i]);
        end
        give_verdict();
    end
endmodule
